// ==== spihp_host.sv ====
`timescale 1ns/1ns
module spihp_host (
	input  wire logic       sys_clk,
	output logic            sck,
	output logic            cs_b,
	output logic [3:0]      lane_in,
	input  wire logic [3:0] dev_out,
	input  wire logic [3:0] dev_oe_b
);
	import spihp_pkg::*;
	logic [3:0] m_val;
	logic [3:0] m_en;
	logic [1:0] width;
	int         half;
	// No pull on the lanes: a released lane shows the inverse of its last value
	assign lane_in = (~dev_oe_b & dev_out) | (dev_oe_b & ((m_en & m_val) | (~m_en & ~m_val)));
	initial begin
		sck = 1'b0;
		cs_b = 1'b1;
		m_val = 4'h0;
		m_en = 4'h0;
		width = WIDTH_SINGLE;
		half = 4;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	task automatic xfer(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
		int         step;
		logic [3:0] msk;
		logic [7:0] sh;
		step = (width == WIDTH_QUAD) ? 4 : (width == WIDTH_DUAL) ? 2 : 1;
		msk = 4'((1 << step) - 1);
		sh = tx;
		rx = 8'h00;
		for (int i = 0; i < 8; i += step) begin
			m_en = drive ? msk : 4'h0;
			m_val = 4'(sh[7:4] >> (4 - step));
			sh = sh << step;
			tick(half);
			sck = 1'b1;
			tick(half);
			// Single mode answers on lane 1 only
			rx = (rx << step) | 8'((step == 1) ? {3'h0, lane_in[1]} : (lane_in & msk));
			sck = 1'b0;
		end
	endtask : xfer
	task automatic frame(input logic [7:0] hdr, input int n, input logic [31:0] wd, output logic [15:0] rd);
		logic [7:0] b;
		rd = 16'h0000;
		// Every frame starts one step past an edge
		tick(1);
		cs_b = 1'b0;
		tick(half);
		xfer(hdr, 1'b1, b);
		for (int k = 0; k < n; k++) begin
			xfer(wd[8*k +: 8], !hdr[7], b);
			if (k < 2) rd[8*k +: 8] = b;
		end
		m_en = 4'h0;
		tick(half);
		cs_b = 1'b1;
		tick(8);
	endtask : frame
endmodule : spihp_host

// ==== spihp_pkg.sv ====
// Overview of operation
// - After reset one lane each way: input on lane 0, output on lane 1.
// - Two-bit lane width: 00 single, 01 dual, 10 quad, 11 reserved; set over the port.
// - A 4 Kbyte command ring is filled by the host and drained in order.
// - Read pointer advances only once the fetched command byte has executed.
// - Timed interrupt fires after a programmed number of milliseconds.
// - Interrupts reach the host by pulling the interrupt output low.
// - Quad mode uses two extra pins as data lanes 2 and 3.
package spihp_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_NS         = 1_000_000;
	localparam int MS_CYCLES_DEF = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_W        = 17;
	localparam int RING_BYTES    = 4096;
	localparam int PTR_W         = $clog2(RING_BYTES);

	localparam logic [1:0] WIDTH_SINGLE = 2'h0;
	localparam logic [1:0] WIDTH_DUAL   = 2'h1;
	localparam logic [1:0] WIDTH_QUAD   = 2'h2;
	localparam logic [1:0] WIDTH_RSVD   = 2'h3;
	localparam logic [1:0] WIDTH_RESET  = WIDTH_SINGLE;

	localparam logic [3:0] STEP_SINGLE = 4'h1;
	localparam logic [3:0] STEP_DUAL   = 4'h2;
	localparam logic [3:0] STEP_QUAD   = 4'h4;
	localparam logic [3:0] BYTE_BITS   = 4'h8;

	localparam logic [3:0] OE_NONE   = 4'hF;
	localparam logic [3:0] OE_SINGLE = 4'hD;
	localparam logic [3:0] OE_DUAL   = 4'hC;
	localparam logic [3:0] OE_QUAD   = 4'h0;

	// Header byte: bit 7 set means read, bits 6:0 select the register
	localparam int         HDR_READ_BIT    = 7;
	localparam logic [6:0] ADDR_LANE_WIDTH = 7'h00;
	localparam logic [6:0] ADDR_CMD_WRITE  = 7'h01;
	localparam logic [6:0] ADDR_CMD_READ   = 7'h02;
	localparam logic [6:0] ADDR_TIMER_MS   = 7'h03;
	localparam logic [6:0] ADDR_STATUS     = 7'h04;
	localparam logic [6:0] ADDR_RING_DATA  = 7'h05;

	typedef enum logic {ENG_IDLE, ENG_RUN} spihp_eng_type;
endpackage : spihp_pkg

// ==== spihp_port.sv ====
`timescale 1ns/1ns
module spihp_port #(
	parameter int MS_CYCLES = spihp_pkg::MS_CYCLES_DEF
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       sck,
	input  wire logic       cs_b,
	input  wire logic       lane0_in,
	output logic            lane0_out,
	output logic            lane0_oe_b,
	input  wire logic       lane1_in,
	output logic            lane1_out,
	output logic            lane1_oe_b,
	input  wire logic       quad_lane_2_in,
	output logic            quad_lane_2_out,
	output logic            quad_lane_2_oe_b,
	input  wire logic       quad_lane_3_in,
	output logic            quad_lane_3_out,
	output logic            quad_lane_3_oe_b,
	output logic            int_b,
	output logic [7:0]      exec_data,
	output logic            exec_strobe
);
	import spihp_pkg::*;

	typedef struct packed {
		logic [1:0]         sck_s;
		logic               sck_d;
		logic [1:0]         cs_s;
		logic [3:0]         ln_s0;
		logic [3:0]         ln_s1;
		logic [1:0]         width;
		logic [1:0]         width_pend;
		logic               pend;
		logic [7:0]         rx_sh;
		logic [3:0]         rx_cnt;
		logic [1:0]         byte_idx;
		logic               hdr_done;
		logic               rd_mode;
		logic [6:0]         addr;
		logic [7:0]         tx_sh;
		logic [3:0]         tx_cnt;
		logic [1:0]         tx_byte;
		logic [PTR_W-1:0]   wr_ptr;
		logic [PTR_W-1:0]   rd_ptr;
		logic [PTR_W-1:0]   stage_off;
		logic [7:0]         lo_hold;
		logic [15:0]        ms_left;
		logic [TICK_W-1:0]  tick;
		logic               irq_flag;
		logic               int_b;
		logic [3:0]         lane_out;
		logic [3:0]         lane_oe_b;
		spihp_eng_type      eng;
		logic [7:0]         exec_data;
		logic               exec_strobe;
		logic               ring_we;
		logic [PTR_W-1:0]   ring_wa;
		logic [7:0]         ring_wd;
	} spihp_state_type;
	spihp_state_type    st_r;
	spihp_state_type    st_nxt;
	logic [7:0]         ring [RING_BYTES];
	logic [7:0]         mem_q;
	function automatic logic [3:0] lane_step(input logic [1:0] w);
		if (w == WIDTH_QUAD) return STEP_QUAD;
		else if (w == WIDTH_DUAL) return STEP_DUAL;
		else return STEP_SINGLE;
	endfunction : lane_step
	function automatic logic [7:0] shift_in(input logic [1:0] w, input logic [7:0] sh, input logic [3:0] ln);
		if (w == WIDTH_QUAD) return {sh[3:0], ln};
		else if (w == WIDTH_DUAL) return {sh[5:0], ln[1:0]};
		else return {sh[6:0], ln[0]};
	endfunction : shift_in
	function automatic logic [3:0] tx_lanes(input logic [1:0] w, input logic [7:0] sh);
		if (w == WIDTH_QUAD) return sh[7:4];
		else if (w == WIDTH_DUAL) return {2'h0, sh[7:6]};
		else return {2'h0, sh[7], 1'h0};
	endfunction : tx_lanes
	function automatic logic [7:0] reg_byte(input logic [6:0] a, input logic [1:0] i, input spihp_state_type s);
		logic [15:0] v;
		v = 16'h0000;
		if (a == ADDR_LANE_WIDTH) v = 16'(s.width);
		else if (a == ADDR_CMD_WRITE) v = 16'(s.wr_ptr);
		else if (a == ADDR_CMD_READ) v = 16'(s.rd_ptr);
		else if (a == ADDR_TIMER_MS) v = s.ms_left;
		else if (a == ADDR_STATUS) v = 16'(s.irq_flag);
		if (i == 2'h0) return v[7:0];
		else if (i == 2'h1) return v[15:8];
		else return 8'h00;
	endfunction : reg_byte
	always_comb begin
		logic [3:0]  step;
		logic [3:0]  cnt;
		logic [7:0]  rx;
		logic [15:0] w16;
		logic        sel;
		logic        set;
		logic        clr;
		step = lane_step(st_r.width);
		cnt = 4'h0;
		rx = 8'h00;
		w16 = 16'h0000;
		sel = ~st_r.cs_s[1];
		set = 1'b0;
		clr = 1'b0;
		st_nxt = st_r;
		st_nxt.sck_s = {st_r.sck_s[0], sck};
		st_nxt.sck_d = st_r.sck_s[1];
		st_nxt.cs_s = {st_r.cs_s[0], cs_b};
		st_nxt.ln_s0 = {quad_lane_3_in, quad_lane_2_in, lane1_in, lane0_in};
		st_nxt.ln_s1 = st_r.ln_s0;
		st_nxt.ring_we = 1'b0;
		st_nxt.exec_strobe = 1'b0;
		// Millisecond countdown
		if (st_r.ms_left != 16'h0000) begin
			if (st_r.tick == TICK_W'(MS_CYCLES - 1)) begin
				st_nxt.tick = '0;
				st_nxt.ms_left = st_r.ms_left - 16'h0001;
				set = (st_r.ms_left == 16'h0001);
			end else begin
				st_nxt.tick = TICK_W'(st_r.tick + 1'b1);
			end
		end
		if (!sel) begin
			// Width switches only between frames so no byte is split across modes
			st_nxt.rx_cnt = 4'h0;
			st_nxt.byte_idx = 2'h0;
			st_nxt.hdr_done = 1'b0;
			st_nxt.rd_mode = 1'b0;
			st_nxt.tx_cnt = 4'h0;
			st_nxt.stage_off = '0;
			if (st_r.pend) begin
				st_nxt.width = st_r.width_pend;
				st_nxt.pend = 1'b0;
			end
		end else begin
			if (st_r.sck_s[1] && !st_r.sck_d) begin
				rx = shift_in(st_r.width, st_r.rx_sh, st_r.ln_s1);
				cnt = st_r.rx_cnt + step;
				st_nxt.rx_sh = rx;
				st_nxt.rx_cnt = (cnt == BYTE_BITS) ? 4'h0 : cnt;
				if (cnt == BYTE_BITS) begin
					w16 = {rx, st_r.lo_hold};
					if (!st_r.hdr_done) begin
						st_nxt.hdr_done = 1'b1;
						st_nxt.rd_mode = rx[HDR_READ_BIT];
						st_nxt.addr = rx[6:0];
						if (rx[HDR_READ_BIT]) begin
							st_nxt.tx_sh = reg_byte(rx[6:0], 2'h0, st_r);
							st_nxt.tx_byte = 2'h1;
							st_nxt.tx_cnt = 4'h0;
							clr = (rx[6:0] == ADDR_STATUS);
						end
					end else if (!st_r.rd_mode) begin
						if (st_r.addr == ADDR_LANE_WIDTH) begin
							if (st_r.byte_idx == 2'h0 && rx[1:0] != WIDTH_RSVD) begin
								st_nxt.width_pend = rx[1:0];
								st_nxt.pend = 1'b1;
							end
						end else if (st_r.addr == ADDR_CMD_WRITE) begin
							if (st_r.byte_idx == 2'h0) st_nxt.lo_hold = rx;
							else if (st_r.byte_idx == 2'h1) st_nxt.wr_ptr = w16[PTR_W-1:0];
						end else if (st_r.addr == ADDR_TIMER_MS) begin
							if (st_r.byte_idx == 2'h0) st_nxt.lo_hold = rx;
							else if (st_r.byte_idx == 2'h1) begin
								st_nxt.ms_left = w16;
								st_nxt.tick = '0;
								set = 1'b0;
							end
						end else if (st_r.addr == ADDR_RING_DATA) begin
							st_nxt.ring_we = 1'b1;
							st_nxt.ring_wa = PTR_W'(st_r.wr_ptr + st_r.stage_off);
							st_nxt.ring_wd = rx;
							st_nxt.stage_off = PTR_W'(st_r.stage_off + 1'b1);
						end
						if (st_r.byte_idx != 2'h3) st_nxt.byte_idx = st_r.byte_idx + 2'h1;
					end
				end
			end
			// Drive on the falling edge; the master samples at the end of the next high phase, just before the falling edge
			if (!st_r.sck_s[1] && st_r.sck_d && st_r.hdr_done && st_r.rd_mode) begin
				st_nxt.lane_out = tx_lanes(st_r.width, st_r.tx_sh);
				st_nxt.tx_sh = st_r.tx_sh << step;
				cnt = st_r.tx_cnt + step;
				st_nxt.tx_cnt = (cnt == BYTE_BITS) ? 4'h0 : cnt;
				if (cnt == BYTE_BITS) begin
					st_nxt.tx_sh = reg_byte(st_r.addr, st_r.tx_byte, st_r);
					if (st_r.tx_byte != 2'h3) st_nxt.tx_byte = st_r.tx_byte + 2'h1;
				end
			end
		end
		if (!sel) st_nxt.lane_oe_b = OE_NONE;
		else if (st_nxt.width == WIDTH_SINGLE) st_nxt.lane_oe_b = OE_SINGLE;
		else if (st_nxt.hdr_done && st_nxt.rd_mode) st_nxt.lane_oe_b = (st_nxt.width == WIDTH_QUAD) ? OE_QUAD : OE_DUAL;
		else st_nxt.lane_oe_b = OE_NONE;
		// A fresh expiry beats a status read in the same cycle
		st_nxt.irq_flag = set | (st_r.irq_flag & ~clr);
		st_nxt.int_b = ~st_nxt.irq_flag;
		case (st_r.eng)
			ENG_IDLE: begin
				if (st_r.rd_ptr != st_r.wr_ptr) st_nxt.eng = ENG_RUN;
			end
			ENG_RUN: begin
				st_nxt.exec_data = mem_q;
				st_nxt.exec_strobe = 1'b1;
				st_nxt.rd_ptr = PTR_W'(st_r.rd_ptr + 1'b1);
				st_nxt.eng = ENG_IDLE;
			end
			default: st_nxt.eng = ENG_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '0;
			st_r.cs_s <= 2'h3;
			st_r.width <= WIDTH_RESET;
			st_r.int_b <= 1'b1;
			st_r.lane_oe_b <= OE_NONE;
		end else begin
			st_r <= st_nxt;
		end
	end
	// Ring storage kept out of reset so it maps onto block memory
	always_ff @(posedge sys_clk) begin
		if (st_r.ring_we) begin
			ring[st_r.ring_wa] <= st_r.ring_wd;
		end
		mem_q <= ring[st_r.rd_ptr];
	end
	assign lane0_out        = st_r.lane_out[0];
	assign lane1_out        = st_r.lane_out[1];
	assign quad_lane_2_out  = st_r.lane_out[2];
	assign quad_lane_3_out  = st_r.lane_out[3];
	assign lane0_oe_b       = st_r.lane_oe_b[0];
	assign lane1_oe_b       = st_r.lane_oe_b[1];
	assign quad_lane_2_oe_b = st_r.lane_oe_b[2];
	assign quad_lane_3_oe_b = st_r.lane_oe_b[3];
	assign int_b            = st_r.int_b;
	assign exec_data        = st_r.exec_data;
	assign exec_strobe      = st_r.exec_strobe;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_run_then_exec;
		st_r.eng == ENG_RUN ##1 st_r.exec_strobe;
	endsequence
	sequence s_last_ms;
		st_r.ms_left == 16'h0001 && st_r.tick == TICK_W'(MS_CYCLES - 1);
	endsequence
	property p_single_lanes;
		st_r.width == WIDTH_SINGLE |-> st_r.lane_oe_b[0] && st_r.lane_oe_b[3:2] == 2'h3;
	endproperty
	a_single_lanes: assert property (p_single_lanes) else $error("single mode drives a wrong lane");
	property p_width_legal;
		st_r.width != WIDTH_RSVD;
	endproperty
	a_width_legal: assert property (p_width_legal) else $error("reserved lane width applied");
	property p_width_frame;
		$changed(st_r.width) |-> $past(st_r.cs_s[1]) && $past(st_r.pend);
	endproperty
	a_width_frame: assert property (p_width_frame) else $error("lane width changed inside a frame");
	property p_fetch;
		st_r.eng == ENG_IDLE && st_r.rd_ptr != st_r.wr_ptr |=> s_run_then_exec;
	endproperty
	a_fetch: assert property (p_fetch) else $error("pending command not executed");
	property p_rd_after_exec;
		$changed(st_r.rd_ptr) |-> st_r.exec_strobe && PTR_W'(st_r.rd_ptr - $past(st_r.rd_ptr)) == PTR_W'(1);
	endproperty
	a_rd_after_exec: assert property (p_rd_after_exec) else $error("read pointer moved without execution");
	property p_timer_expire;
		s_last_ms |=> st_r.irq_flag && st_r.ms_left == 16'h0000 && !st_r.int_b;
	endproperty
	a_timer_expire: assert property (p_timer_expire) else $error("timer expiry did not interrupt");
	property p_frame_idle;
		st_r.cs_s[1] |=> st_r.lane_oe_b == OE_NONE;
	endproperty
	a_frame_idle: assert property (p_frame_idle) else $error("lanes driven while deselected");
	property p_irq_pin;
		$rose(st_r.irq_flag) |-> !st_r.int_b ##1 (!st_r.int_b || !$past(st_r.irq_flag) || !st_r.irq_flag);
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("interrupt flag not shown low on pin");
	property p_quad_lanes;
		st_r.lane_oe_b[3:2] != 2'h3 |-> st_r.width == WIDTH_QUAD;
	endproperty
	a_quad_lanes: assert property (p_quad_lanes) else $error("lanes 2/3 driven outside quad");
	property p_empty_idle;
		st_r.eng == ENG_IDLE && st_r.rd_ptr == st_r.wr_ptr |=> !st_r.exec_strobe;
	endproperty
	a_empty_idle: assert property (p_empty_idle) else $error("engine ran on empty ring");
endmodule : spihp_port

// ==== spihp_port_bench.sv ====
`timescale 1ns/1ns
module spihp_port_bench;
	import spihp_pkg::*;
	logic        sys_clk;
	logic        rst_b;
	logic        sck;
	logic        cs_b;
	logic        int_b;
	logic        exec_strobe;
	logic [3:0]  lane_in;
	logic [3:0]  lane_out;
	logic [3:0]  lane_oe_b;
	logic [7:0]  exec_data;
	logic [7:0]  exec_q[$];
	logic [15:0] rv;
	int          mismatches;
	int          samples_checked;
	int          n;
	spihp_port #(.MS_CYCLES(10)) spihp_port_inst (.sys_clk(sys_clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b),
		.lane0_in(lane_in[0]), .lane0_out(lane_out[0]), .lane0_oe_b(lane_oe_b[0]),
		.lane1_in(lane_in[1]), .lane1_out(lane_out[1]), .lane1_oe_b(lane_oe_b[1]),
		.quad_lane_2_in(lane_in[2]), .quad_lane_2_out(lane_out[2]), .quad_lane_2_oe_b(lane_oe_b[2]),
		.quad_lane_3_in(lane_in[3]), .quad_lane_3_out(lane_out[3]), .quad_lane_3_oe_b(lane_oe_b[3]),
		.int_b(int_b), .exec_data(exec_data), .exec_strobe(exec_strobe));
	spihp_host spihp_host_inst (.sys_clk(sys_clk), .sck(sck), .cs_b(cs_b), .lane_in(lane_in),
		.dev_out(lane_out), .dev_oe_b(lane_oe_b));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (exec_strobe === 1'b1) exec_q.push_back(exec_data);
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [6:0] idx, input int cnt, input logic [31:0] v);
		logic [15:0] d;
		spihp_host_inst.frame({1'b0, idx}, cnt, v, d);
	endtask : wr
	task automatic rd(input logic [6:0] idx, output logic [15:0] v);
		spihp_host_inst.frame({1'b1, idx}, 2, 32'h0000_0000, v);
	endtask : rd
	task automatic wait_exec(input int cnt);
		int k;
		k = 0;
		while (exec_q.size() < cnt && k < 20000) begin
			@(posedge sys_clk);
			k++;
		end
		if (k == 20000) begin
			mismatches++;
			stop_test();
		end
	endtask : wait_exec
	// Executed bytes must come out in ring order, then nothing more
	task automatic chk_ring(input logic [31:0] exp);
		repeat (20) @(posedge sys_clk);
		chk(16'(exec_q.size()), 16'h0004);
		for (int k = 0; k < 4 && k < exec_q.size(); k++) chk(16'(exec_q[k]), 16'(exp[8*k +: 8]));
		exec_q.delete();
	endtask : chk_ring
	initial begin
		rst_b = 1'b0;
		mismatches = 0;
		samples_checked = 0;
		repeat (16) @(posedge sys_clk);
		#1 rst_b = 1'b1;
		chk(16'({lane_oe_b, int_b, 2'h0, exec_strobe}), 16'h00F8);
		repeat (4) @(posedge sys_clk);
		rd(ADDR_LANE_WIDTH, rv);
		chk(rv, 16'h0000);
		wr(ADDR_RING_DATA, 4, 32'h4433_2211);
		repeat (40) @(posedge sys_clk);
		chk(16'(exec_q.size()), 16'h0000);
		wr(ADDR_CMD_WRITE, 2, 32'h0000_0004);
		wait_exec(4);
		chk_ring(32'h4433_2211);
		wr(ADDR_CMD_READ, 2, 32'h0000_0100);
		rd(ADDR_CMD_READ, rv);
		chk(rv, 16'h0004);
		wr(ADDR_CMD_WRITE, 2, 32'h0000_0FFE);
		wait_exec(4090);
		exec_q.delete();
		wr(ADDR_RING_DATA, 4, 32'hDDCC_BBAA);
		wr(ADDR_CMD_WRITE, 2, 32'h0000_0002);
		wait_exec(4);
		chk_ring(32'hDDCC_BBAA);
		rd(ADDR_CMD_READ, rv);
		chk(rv, 16'h0002);
		rd(ADDR_CMD_WRITE, rv);
		chk(rv, 16'h0002);
		wr(ADDR_TIMER_MS, 2, 32'h0000_0005);
		chk(16'(int_b), 16'h0001);
		n = 0;
		while (int_b !== 1'b0 && n < 80) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n == 80) begin
			mismatches++;
			stop_test();
		end
		chk(16'(n >= 25 && n <= 45), 16'h0001);
		rd(ADDR_STATUS, rv);
		chk(16'({int_b, rv[0]}), 16'h0003);
		@(posedge sys_clk);
		chk(16'(int_b), 16'h0001);
		rd(ADDR_TIMER_MS, rv);
		chk(rv, 16'h0000);
		wr(ADDR_LANE_WIDTH, 2, 32'(WIDTH_RSVD));
		rd(ADDR_LANE_WIDTH, rv);
		chk(rv, 16'h0000);
		// Quad also runs with a slow serial clock
		for (int m = 1; m < 3; m++) begin
			wr(ADDR_LANE_WIDTH, 2, 32'(m));
			spihp_host_inst.width = 2'(m);
			spihp_host_inst.half = 4 * m;
			rd(ADDR_LANE_WIDTH, rv);
			chk(rv, 16'(m));
			rd(ADDR_CMD_READ, rv);
			chk(rv, 16'h0002);
			// Status header puts a one on lane 2 in quad
			rd(ADDR_STATUS, rv);
			chk(rv, 16'h0000);
		end
		wr(ADDR_LANE_WIDTH, 2, 32'(WIDTH_SINGLE));
		spihp_host_inst.width = WIDTH_SINGLE;
		spihp_host_inst.half = 4;
		rd(ADDR_LANE_WIDTH, rv);
		chk(rv, 16'h0000);
		rd(7'h7F, rv);
		chk(rv, 16'h0000);
		stop_test();
	end
endmodule : spihp_port_bench
